// *** logic/sgs_defs.vh ***
// Purpose: Shared constants for the stereo glasses sync block.
// Assumes: Core clock of 125 MHz; times are held in nanoseconds.
// Notes: The cycle limits below follow from these times at an 8 ns period.
`ifndef SGS_DEFS_VH
`define SGS_DEFS_VH

// ============================================================
// Clock
`define SGS_CLK_PERIOD_NS 8

// ============================================================
// Pulse timing limits, in nanoseconds
`define SGS_WIDTH_MIN_NS 20000
`define SGS_WIDTH_MAX_NS 32000
`define SGS_BASE_MIN_NS 500000
`define SGS_DELTA_MIN_NS 128000
`define SGS_DELTA_MAX_NS 163000
`define SGS_GUARD_MIN_NS 2000000

// ============================================================
// Pulse timing limits, in core clock cycles
// A strict lower bound takes one cycle above the floor of the time, so the
// limit holds with no rounding margin left to chance.
`define SGS_WIDTH_MIN_CYC 12'h9C4
`define SGS_WIDTH_MAX_CYC 12'hFA0
`define SGS_BASE_MIN_CYC 22'hF425
`define SGS_DELTA_MIN_CYC 22'h3E80
`define SGS_DELTA_MAX_CYC 22'h4F97
`define SGS_GUARD_MIN_CYC 22'h3D091

// ============================================================
// Field widths
`define SGS_CNT_W 22
`define SGS_WIDTH_W 12
`define SGS_DELTA_W 15
`define SGS_LED_N 3

// ============================================================
// Pulse colour select codes and channel positions
`define SGS_COLOR_RED 2'h0
`define SGS_COLOR_GREEN 2'h1
`define SGS_COLOR_BLUE 2'h2
`define SGS_MASK_RED 3'h1
`define SGS_MASK_GREEN 3'h2
`define SGS_MASK_BLUE 3'h4

// ============================================================
// Reset values
`define SGS_CNT_ZERO 22'h0
`define SGS_CNT_ONE 22'h1
`define SGS_CNT_MAX 22'h3FFFFF
`define SGS_LED_OFF 3'h0

`endif

// *** logic/sgs_clamp.v ***
// Purpose: Limits a timing value into a closed range.
// Assumes: LO is not above HI.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/100ps

module sgs_clamp #(
  parameter W = 22,
  parameter [W-1:0] LO = 0,
  parameter [W-1:0] HI = 1
) (
  // Value in and limited value out
  input wire [W-1:0] val_i,
  output wire [W-1:0] val_o
);

  assign val_o = (val_i < LO) ? LO : ((val_i > HI) ? HI : val_i);

endmodule // sgs_clamp

// *** logic/sgs_stereo_sync.v ***
// Purpose: Left/right shutter sync for active 3D glasses, by IR strobe or light pulse.
// Assumes: frame_start_i is a one-cycle pulse from display timing on core_clk_i.
// Notes: The pulse is placed against the previous frame's measured length.
//
// How it works
// RL1: With stereo detected and enabled, sync follows each displayed frame and eye.
// RL2: In IR mode the sync output carries the eye level for an IR transmitter.
// RL3: In light mode at most one pulse per frame, inside the dark interval.
// RL4: The pulse drives the illumination driver's LED enable of the selected colour on.
// RL5: LEDs stay off throughout the dark interval except during the pulse.
// RL6: Pulse colour is selectable; code zero and unknown codes give red.
// RL7: Pulse offset before frame end alternates between base and base plus delta.
// RL8: Pulse width is held between 20 and 32 microseconds.
// RL9: Base offset is held above 500 microseconds.
// RL10: Delta offset is held between 128 and 163 microseconds.
// RL11: A pulse waits until more than 2000 microseconds passed since the last one.
// RL12: Glasses close both shutters, then open the next eye after the pulse.
// RL13: Combined offset equals base plus delta, held at the 22-bit maximum when the sum overflows.
// RL14: IR sync level toggles at each frame boundary; high means left eye.
// RL15: Timing set is taken from inputs and updated only at frame boundaries.
`timescale 1ns/100ps
`include "sgs_defs.vh"

module sgs_stereo_sync #(
  parameter [21:0] BASE_MIN_CYC = `SGS_BASE_MIN_CYC,
  parameter [21:0] DELTA_MIN_CYC = `SGS_DELTA_MIN_CYC,
  parameter [21:0] DELTA_MAX_CYC = `SGS_DELTA_MAX_CYC,
  parameter [21:0] GUARD_MIN_CYC = `SGS_GUARD_MIN_CYC
) (
  // Clock and reset
  input wire core_clk_i,
  input wire rstn_i,
  // Stereo control
  input wire stereo_en_i,
  input wire stereo_det_i,
  input wire light_mode_i,
  input wire [1:0] color_sel_i,
  // Display frame timing
  input wire frame_start_i,
  // Per-frame-rate timing set, in core clock cycles
  input wire [`SGS_WIDTH_W-1:0] pulse_width_cyc_i,
  input wire [`SGS_CNT_W-1:0] base_offset_cyc_i,
  input wire [`SGS_DELTA_W-1:0] delta_offset_cyc_i,
  // Illumination driver
  input wire [`SGS_LED_N-1:0] video_led_i,
  output wire [`SGS_LED_N-1:0] led_en_o,
  // Sync outputs
  output wire ir_sync_o,
  output wire eye_left_o,
  output wire dark_o,
  output wire pulse_o,
  output wire [`SGS_CNT_W-1:0] comb_offset_o
);

  // ============================================================
  // Derived limits
  localparam [`SGS_WIDTH_W-1:0] WIDTH_MIN_CYC = `SGS_WIDTH_MIN_CYC;
  localparam [`SGS_WIDTH_W-1:0] WIDTH_MAX_CYC = `SGS_WIDTH_MAX_CYC;
  localparam [`SGS_DELTA_W-1:0] DMIN = DELTA_MIN_CYC[`SGS_DELTA_W-1:0];
  localparam [`SGS_DELTA_W-1:0] DMAX = DELTA_MAX_CYC[`SGS_DELTA_W-1:0];

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_PULSE = 2'h2;
  localparam [1:0] ST_DONE = 2'h3;

  // ============================================================
  // Pin synchroniser for the stereo detect input
  reg det_meta_reg;
  reg det_sync_reg;

  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      det_meta_reg <= 1'b0;
      det_sync_reg <= 1'b0;
    end
    else
    begin
      det_meta_reg <= stereo_det_i;
      det_sync_reg <= det_meta_reg;
    end
  end

  wire active = stereo_en_i & det_sync_reg; // RL1

  // ============================================================
  // Timing set limits
  wire [`SGS_WIDTH_W-1:0] width_lim;
  wire [`SGS_CNT_W-1:0] base_lim;
  wire [`SGS_DELTA_W-1:0] delta_lim;

  sgs_clamp #(
    .W(`SGS_WIDTH_W),
    .LO(WIDTH_MIN_CYC),
    .HI(WIDTH_MAX_CYC)
  ) u_width_clamp (
    .val_i(pulse_width_cyc_i),
    .val_o(width_lim)
  ); // RL8

  sgs_clamp #(
    .W(`SGS_CNT_W),
    .LO(BASE_MIN_CYC),
    .HI(`SGS_CNT_MAX)
  ) u_base_clamp (
    .val_i(base_offset_cyc_i),
    .val_o(base_lim)
  ); // RL9

  sgs_clamp #(
    .W(`SGS_DELTA_W),
    .LO(DMIN),
    .HI(DMAX)
  ) u_delta_clamp (
    .val_i(delta_offset_cyc_i),
    .val_o(delta_lim)
  ); // RL10

  // ============================================================
  // Frame-boundary registers
  reg [`SGS_WIDTH_W-1:0] width_reg;
  reg [`SGS_CNT_W-1:0] base_reg;
  reg [`SGS_CNT_W-1:0] comb_reg;
  reg [`SGS_CNT_W-1:0] frame_cnt_reg;
  reg [`SGS_CNT_W-1:0] frame_len_reg;
  reg eye_left_reg;
  reg [1:0] color_reg;

  wire [`SGS_CNT_W:0] comb_sum = {1'b0, base_lim} + {8'h00, delta_lim};
  wire [`SGS_CNT_W-1:0] comb_sat = comb_sum[`SGS_CNT_W] ? `SGS_CNT_MAX
    : comb_sum[`SGS_CNT_W-1:0];

  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      width_reg <= WIDTH_MIN_CYC;
      base_reg <= BASE_MIN_CYC;
      comb_reg <= BASE_MIN_CYC + DELTA_MIN_CYC;
      frame_cnt_reg <= `SGS_CNT_ZERO;
      frame_len_reg <= `SGS_CNT_ZERO;
      eye_left_reg <= 1'b0;
      color_reg <= `SGS_COLOR_RED;
    end
    else if (frame_start_i)
    begin
      width_reg <= width_lim; // RL15
      base_reg <= base_lim; // RL15
      comb_reg <= comb_sat; // RL13
      color_reg <= color_sel_i; // RL15
      frame_len_reg <= frame_cnt_reg;
      frame_cnt_reg <= `SGS_CNT_ONE;
      eye_left_reg <= active ? ~eye_left_reg : 1'b0; // RL14
    end
    else if (frame_cnt_reg != `SGS_CNT_MAX)
    begin
      frame_cnt_reg <= frame_cnt_reg + `SGS_CNT_ONE;
    end
  end

  // ============================================================
  // Pulse placement
  // Left frames use the base offset, right frames base plus delta; the
  // glasses tell the eye apart from this spacing alone.
  wire [`SGS_CNT_W-1:0] offset_sel = eye_left_reg ? base_reg : comb_reg; // RL7
  wire [`SGS_CNT_W:0] dark_span = {1'b0, comb_reg} + {11'h000, width_reg};
  // A frame too short to hold the dark interval gets no pulse at all.
  wire fits = ({1'b0, frame_len_reg} > dark_span);
  wire [`SGS_CNT_W-1:0] start_pt = frame_len_reg - offset_sel;
  wire [`SGS_CNT_W:0] dark_pt_w = {1'b0, frame_len_reg} - dark_span;
  wire [`SGS_CNT_W-1:0] dark_pt = dark_pt_w[`SGS_CNT_W-1:0];

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [`SGS_WIDTH_W-1:0] pcnt_reg;
  reg [`SGS_WIDTH_W-1:0] pcnt_next;
  reg [`SGS_CNT_W-1:0] guard_cnt_reg;
  reg dark_reg;
  reg dark_next;
  reg pulse_reg;

  wire guard_ok = (guard_cnt_reg >= GUARD_MIN_CYC); // RL11
  wire light_on = active & light_mode_i;

  always @*
  begin
    state_next = state_reg;
    pcnt_next = pcnt_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (frame_start_i & light_on)
        begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (frame_start_i | ~light_on)
        begin
          state_next = light_on ? ST_WAIT : ST_IDLE;
        end
        else if (fits & guard_ok & (frame_cnt_reg >= start_pt))
        begin
          state_next = ST_PULSE; // RL3
          pcnt_next = width_reg;
        end
      end
      ST_PULSE:
      begin
        if (pcnt_reg == {{(`SGS_WIDTH_W-1){1'b0}}, 1'b1})
        begin
          state_next = ST_DONE;
        end
        pcnt_next = pcnt_reg - {{(`SGS_WIDTH_W-1){1'b0}}, 1'b1};
      end
      ST_DONE:
      begin
        // One pulse only until the next frame boundary.
        if (frame_start_i)
        begin
          state_next = light_on ? ST_WAIT : ST_IDLE; // RL3
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @*
  begin
    dark_next = 1'b0;
    if (light_on & fits & ~frame_start_i & (frame_cnt_reg >= dark_pt))
    begin
      dark_next = 1'b1; // RL12
    end
    if (state_next == ST_PULSE)
    begin
      dark_next = 1'b1;
    end
  end

  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      state_reg <= ST_IDLE;
      pcnt_reg <= {`SGS_WIDTH_W{1'b0}};
      guard_cnt_reg <= `SGS_CNT_MAX;
      dark_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      pcnt_reg <= pcnt_next;
      dark_reg <= dark_next;
      pulse_reg <= (state_next == ST_PULSE); // RL4
      if (state_next == ST_PULSE)
      begin
        guard_cnt_reg <= `SGS_CNT_ZERO; // RL11
      end
      else if (guard_cnt_reg != `SGS_CNT_MAX)
      begin
        guard_cnt_reg <= guard_cnt_reg + `SGS_CNT_ONE;
      end
    end
  end

  // ============================================================
  // Illumination enables
  reg [`SGS_LED_N-1:0] color_mask;

  always @*
  begin
    case (color_reg)
      `SGS_COLOR_GREEN: color_mask = `SGS_MASK_GREEN;
      `SGS_COLOR_BLUE: color_mask = `SGS_MASK_BLUE;
      default: color_mask = `SGS_MASK_RED; // RL6
    endcase
  end

  wire pulse_next = (state_next == ST_PULSE);

  genvar gi;
  generate
    for (gi = 0; gi < `SGS_LED_N; gi = gi + 1)
    begin : g_led
      reg led_reg;
      always @(posedge core_clk_i)
      begin
        if (!rstn_i)
        begin
          led_reg <= 1'b0;
        end
        else if (dark_next)
        begin
          led_reg <= pulse_next & color_mask[gi]; // RL5
        end
        else
        begin
          led_reg <= video_led_i[gi];
        end
      end
      assign led_en_o[gi] = led_reg; // RL4
    end
  endgenerate

  // ============================================================
  // Outputs
  reg ir_sync_reg;

  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      ir_sync_reg <= 1'b0;
    end
    else
    begin
      ir_sync_reg <= active & ~light_mode_i & eye_left_reg; // RL2
    end
  end

  assign ir_sync_o = ir_sync_reg;
  assign eye_left_o = eye_left_reg;
  assign dark_o = dark_reg;
  assign pulse_o = pulse_reg;
  assign comb_offset_o = comb_reg;

endmodule // sgs_stereo_sync

// *** dv/sgs_glasses_model.sv ***
// Purpose: Shutter glasses seen through the lens, fed by the LED enables.
// Assumes: Any lit LED channel reaches the glasses' light sensor.
// Notes: Reports each light burst: count, length and colour.
`timescale 1ns/100ps

module sgs_glasses_model (
  // Clock
  input wire core_clk_i,
  // Light from the illumination driver
  input wire [2:0] led_i,
  // Observations
  output reg [7:0] pulses_o = 8'h0,
  output reg [11:0] width_o = 12'h0,
  output reg [2:0] colour_o = 3'h0,
  output reg left_open_o = 1'b0
);
  reg [11:0] run_reg = 12'h0;

  always @(posedge core_clk_i)
  begin
    if (|led_i)
    begin
      run_reg <= run_reg + 12'h1;
      colour_o <= led_i;
    end
    else if (run_reg != 12'h0)
    begin
      // Both shutters were shut for the burst; the next eye opens only now.
      pulses_o <= pulses_o + 8'h1;
      width_o <= run_reg;
      run_reg <= 12'h0;
      left_open_o <= ~left_open_o;
    end
  end
endmodule // sgs_glasses_model

// *** dv/sgs_stereo_sync_chk.sv ***
// Purpose: Port assertions for the stereo glasses sync block.
// Assumes: One clock; rstn_i synchronous, active low.
// Notes: Parameters come from the design through the bind.
`timescale 1ns/100ps

module sgs_stereo_sync_chk #(
  parameter [21:0] BASE_MIN_CYC = 22'h1,
  parameter [21:0] DELTA_MIN_CYC = 22'h1,
  parameter [21:0] DELTA_MAX_CYC = 22'h1,
  parameter [21:0] GUARD_MIN_CYC = 22'h1
) (
  // Inputs of the block
  input wire core_clk_i,
  input wire rstn_i,
  input wire stereo_en_i,
  input wire stereo_det_i,
  input wire light_mode_i,
  input wire frame_start_i,
  input wire [21:0] base_offset_cyc_i,
  input wire [14:0] delta_offset_cyc_i,
  // Outputs of the block
  input wire [2:0] led_en_o,
  input wire ir_sync_o,
  input wire eye_left_o,
  input wire dark_o,
  input wire pulse_o,
  input wire [21:0] comb_offset_o
);
  // ==========
  // Helpers
  // The pulse lasts thousands of cycles, too long for a repetition.
  reg [11:0] hi_reg;
  reg [1:0] rise_reg;
  wire rise = pulse_o && (hi_reg == 12'h0);

  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      hi_reg <= 12'h0;
      rise_reg <= 2'h0;
    end
    else
    begin
      hi_reg <= pulse_o ? hi_reg + 12'h1 : 12'h0;
      rise_reg <= frame_start_i ? 2'h0 : rise_reg + {1'b0, rise && rise_reg != 2'h3};
    end
  end

  default clocking dc @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // ==========
  // Assertions
  sequence s_live;
    (stereo_en_i && stereo_det_i) [*4];
  endsequence
  sequence s_new_frame;
    frame_start_i && base_offset_cyc_i >= BASE_MIN_CYC
      && delta_offset_cyc_i >= DELTA_MIN_CYC && delta_offset_cyc_i <= DELTA_MAX_CYC;
  endsequence

  chk_width_range:
    assert property ($fell(pulse_o) |-> hi_reg >= 12'h9C4 && hi_reg <= 12'hFA0)
    else $error("pulse width out of range");
  chk_one_pulse:
    assert property (rise_reg <= 2'h1) else $error("two pulses in a frame");
  chk_pulse_dark:
    assert property (pulse_o |-> dark_o && $onehot(led_en_o)) else $error("pulse lighting");
  chk_dark_unlit:
    assert property (dark_o && !pulse_o |-> led_en_o == 3'h0) else $error("light in dark");
  chk_eye_toggle:
    assert property (s_live ##0 frame_start_i |=> eye_left_o != $past(eye_left_o))
    else $error("eye did not toggle");
  chk_ir_level:
    assert property ((!light_mode_i && stereo_en_i && stereo_det_i) [*5]
      |-> ir_sync_o == $past(eye_left_o)) else $error("ir level");
  chk_ir_quiet:
    assert property ((light_mode_i || !stereo_en_i) [*2] |-> !ir_sync_o) else $error("ir idle");
  chk_comb_sum:
    assert property (s_new_frame |=> comb_offset_o
      == $past(base_offset_cyc_i) + {7'h0, $past(delta_offset_cyc_i)}) else $error("comb sum");
  chk_comb_hold:
    assert property (!frame_start_i |=> $stable(comb_offset_o)) else $error("comb moved");
endmodule // sgs_stereo_sync_chk

// *** dv/sgs_stereo_sync_test.sv ***
// Purpose: Self-checking bench for the stereo glasses sync block.
// Assumes: 125 MHz clock; inputs change on the falling edge.
// Notes: Small offset limits; the fixed width floor sets frames of 5200 cycles.
`timescale 1ns/100ps

module sgs_stereo_sync_test;
  localparam [21:0] BMIN = 22'h14;
  localparam [21:0] DMIN = 22'h5;
  // The base offset must exceed the 2500-cycle width floor so the pulse ends
  // inside its own frame; the frame must exceed base plus delta plus width.
  localparam [21:0] BASE = 22'hA28;
  localparam int FLEN = 32'h1450;
  reg core_clk_i = 1'b0;
  reg rstn_i = 1'b0;
  reg stereo_en_i = 1'b0;
  reg stereo_det_i = 1'b0;
  reg light_mode_i = 1'b0;
  reg [1:0] color_sel_i = 2'h0;
  reg frame_start_i = 1'b0;
  reg [11:0] pulse_width_cyc_i = 12'h0;
  reg [21:0] base_offset_cyc_i = 22'h0;
  reg [14:0] delta_offset_cyc_i = 15'h0;
  reg [2:0] video_led_i = 3'h0;
  wire [2:0] led_en_o;
  wire ir_sync_o, eye_left_o, dark_o, pulse_o;
  wire [21:0] comb_offset_o;
  wire [7:0] pulses;
  wire [11:0] width;
  wire [2:0] colour;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;

  sgs_stereo_sync #(
    .BASE_MIN_CYC(BMIN),
    .DELTA_MIN_CYC(DMIN),
    .DELTA_MAX_CYC(22'h8),
    .GUARD_MIN_CYC(22'h1E)
  ) i_sgs_stereo_sync (
    .core_clk_i, .rstn_i, .stereo_en_i, .stereo_det_i, .light_mode_i, .color_sel_i,
    .frame_start_i, .pulse_width_cyc_i, .base_offset_cyc_i, .delta_offset_cyc_i,
    .video_led_i, .led_en_o, .ir_sync_o, .eye_left_o, .dark_o, .pulse_o, .comb_offset_o
  );

  sgs_glasses_model i_sgs_glasses_model (
    .core_clk_i,
    .led_i(led_en_o),
    .pulses_o(pulses),
    .width_o(width),
    .colour_o(colour),
    .left_open_o()
  );

  always #4 core_clk_i = ~core_clk_i;

  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 32'h13880)
    begin
      err_total++;
      end_sim;
    end
  end

  task end_sim;
    $display("compared %0d wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // One frame boundary, then the cycle offset of the first pulse cycle.
  task automatic frame(input int len, output int pos);
    pos = 0;
    @(negedge core_clk_i) frame_start_i = 1'b1;
    @(negedge core_clk_i) frame_start_i = 1'b0;
    for (int k = 1; k < len; k++)
    begin
      if (pulse_o === 1'b1 && pos == 0)
        pos = k;
      @(negedge core_clk_i);
    end
  endtask

  task t_reset;
    @(negedge core_clk_i);
    chk(led_en_o, 3'h0, "led");
    chk({ir_sync_o, eye_left_o, dark_o, pulse_o}, 4'h0, "flags");
    chk(comb_offset_o, BMIN + DMIN, "comb");
  endtask

  task t_ir;
    int p;
    stereo_en_i = 1'b1;
    stereo_det_i = 1'b1;
    video_led_i = 3'h5;
    base_offset_cyc_i = BASE;
    delta_offset_cyc_i = 15'h6;
    repeat (4) @(negedge core_clk_i);
    for (int i = 0; i < 4; i++)
    begin
      frame(20, p);
      chk(eye_left_o, i % 2 == 0, "eye");
      chk(ir_sync_o, i % 2 == 0, "ir");
      chk(led_en_o, 3'h5, "video");
    end
    chk(comb_offset_o, BASE + 22'h6, "comb in range");
    stereo_en_i = 1'b0;
    frame(20, p);
    chk({eye_left_o, ir_sync_o}, 2'h0, "idle");
  endtask

  task t_light;
    int p1, p2;
    reg [7:0] n;
    light_mode_i = 1'b1;
    stereo_en_i = 1'b1;
    video_led_i = 3'h0;
    pulse_width_cyc_i = 12'h64;
    base_offset_cyc_i = BASE;
    delta_offset_cyc_i = 15'h1;
    frame(FLEN, p1);
    for (int c = 0; c < 4; c++)
    begin
      color_sel_i = c[1:0];
      n = pulses;
      frame(FLEN, p1);
      frame(FLEN, p2);
      chk(pulses - n, 8'h2, "count");
      chk(colour, c == 1 ? 3'h2 : c == 2 ? 3'h4 : 3'h1, "colour");
      chk(width, 12'h9C4, "width");
      chk(p1 > p2 ? p1 - p2 : p2 - p1, DMIN, "delta");
      chk(comb_offset_o, BASE + DMIN, "comb");
    end
    base_offset_cyc_i = 22'h5;
    @(negedge core_clk_i);
    chk(comb_offset_o, BASE + DMIN, "hold");
    frame(FLEN, p1);
    chk(comb_offset_o, BMIN + DMIN, "clamp");
  endtask

  initial
  begin
    repeat (5) @(negedge core_clk_i);
    rstn_i = 1'b1;
    t_reset;
    t_ir;
    t_light;
    end_sim;
  end
endmodule // sgs_stereo_sync_test

bind sgs_stereo_sync sgs_stereo_sync_chk #(
  .BASE_MIN_CYC(BASE_MIN_CYC),
  .DELTA_MIN_CYC(DELTA_MIN_CYC),
  .DELTA_MAX_CYC(DELTA_MAX_CYC),
  .GUARD_MIN_CYC(GUARD_MIN_CYC)
) i_sgs_stereo_sync_chk (
  .core_clk_i, .rstn_i, .stereo_en_i, .stereo_det_i, .light_mode_i, .frame_start_i,
  .base_offset_cyc_i, .delta_offset_cyc_i, .led_en_o, .ir_sync_o, .eye_left_o,
  .dark_o, .pulse_o, .comb_offset_o
);
